// >>> mmt_pkg.sv
package mmt_pkg;
   localparam logic [7:0]  ADDR_RELOAD_LO = 8'hAA;
   localparam logic [7:0]  ADDR_RELOAD_HI = 8'hAB;
   localparam logic [7:0]  ADDR_COUNT_LO  = 8'hAC;
   localparam logic [7:0]  ADDR_COUNT_HI  = 8'hAD;
   localparam logic [7:0]  ADDR_CONTROL   = 8'hAE;

   localparam logic [15:0] COUNT_RESET    = 16'hFFFF;
   localparam logic [15:0] RELOAD_RESET   = 16'h0000;
   localparam logic [7:0]  CONTROL_RESET  = 8'h00;
   localparam logic [15:0] COUNT_ZERO     = 16'h0000;
   localparam logic [15:0] COUNT_FULL     = 16'hFFFF;
   localparam logic [7:0]  READ_UNMAPPED  = 8'h00;

   localparam int MODE_HI_BIT  = 7;
   localparam int MODE_LO_BIT  = 5;
   localparam int RUN_BIT      = 4;
   localparam int PEND_BIT     = 3;
   localparam int IEN_BIT      = 2;
   localparam int CAPTYPE_BIT  = 1;

   localparam logic [2:0] MODE_EVT_RISE  = 3'b000;
   localparam logic [2:0] MODE_EVT_FALL  = 3'b001;
   localparam logic [2:0] MODE_PWM_TGL   = 3'b101;
   localparam logic [2:0] MODE_PWM_PLAIN = 3'b100;
   localparam logic [2:0] MODE_CAP_RISE  = 3'b010;
   localparam logic [2:0] MODE_CAP_FALL  = 3'b011;
endpackage

// >>> mmt_edge_if.sv
`timescale 1ns/1ps
interface mmt_edge_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface

// >>> mmt_pin_sense.sv
`timescale 1ns/1ps
module mmt_pin_sense (
   input  wire logic mclk,
   input  wire logic arst_n,
   input  wire logic pin_in,
   mmt_edge_if.src   edges
);
   logic sync1_q;
   logic sync2_q;
   logic prev_q;

   // only sync2_q reads sync1_q; edges compare two settled samples
   // reset to the pulled-up idle level so no false rise follows reset
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_q <= 1'b1;
         sync2_q <= 1'b1;
         prev_q  <= 1'b1;
      end else begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   assign edges.level = sync2_q;
   assign edges.rise  = sync2_q & ~prev_q; // see (R19)
   assign edges.fall  = ~sync2_q & prev_q; // see (R19)
endmodule

// >>> mmt_timer.sv
// Contract
// (R1) 16-bit count, 16-bit reload/capture and 8-bit control, 16-bit ones as byte pairs.
// (R2) Reset: count 0xFFFF, reload/capture 0x0000, control 0x00.
// (R3) Control bit 4 starts (1) or stops (0) the counter outside capture modes.
// (R4) Running counter decrements once per timer clock: instruction clock or pin edge.
// (R5) Underflow from 0x0000 reloads 0xFFFF or reload value; may interrupt and toggle pin.
// (R6) Control bit 2 enables the interrupt; source is underflow and/or capture.
// (R7) Control bit 3 is the interrupt pending flag.
// (R8) In capture modes bit 4 is the underflow pending flag.
// (R9) Bit 1 picks pulse (opposite edges) or cycle (same edges) capture; bit 0 reserved.
// (R10) Modes 000/001 count rising/falling pin edges, interrupt on underflow.
// (R11) Modes 101/100 count clocks with auto-reload; 101 toggles the pin on underflow.
// (R12) Modes 010/011 capture on rising/falling edge, counting clocks, interrupt on edge.
// (R13) Modes 11x difference capture; bits 5 and 1 choose the edge pair.
// (R14) Timer pin is shared with a port pin, input or output by mode; the code takes its direction from port_drive_en in every mode.
// (R15) Pending flag sets on every underflow in pulse-width and event modes.
// (R16) Core interrupt needs timer enable and global enable both set.
// (R17) Capture copies the current count into the reload/capture register.
// (R18) Pin edges from outside come no faster than half the instruction clock.
// (R19) Pin is sampled on the instruction clock; edges come from successive samples.
`timescale 1ns/1ps
module mmt_timer (
   input  wire logic       mclk,
   input  wire logic       arst_n,
   input  wire logic [7:0] bus_addr,
   input  wire logic [7:0] bus_wdata,
   input  wire logic       bus_wr,
   input  wire logic       bus_rd,
   output logic      [7:0] bus_rdata,
   input  wire logic       global_irq_enable,
   output logic            timer_interrupt,
   input  wire logic       port_data_out,
   input  wire logic       port_drive_en,
   input  wire logic       shared_port_pin_in,
   output logic            shared_port_pin_out,
   output logic            shared_port_pin_oe
);
   logic [15:0] count_q;
   logic [15:0] count_d;
   logic [15:0] reload_q;
   logic [15:0] reload_d;
   logic [7:0]  ctrl_q;
   logic [7:0]  ctrl_d;
   logic        toggle_q;
   logic        toggle_d;
   logic        armed_q;
   logic        armed_d;
   logic [7:0]  rdata_q;

   mmt_edge_if edges ();

   mmt_pin_sense u_sense (
      .mclk   (mclk),
      .arst_n (arst_n),
      .pin_in (shared_port_pin_in),
      .edges  (edges)
   );

   // register decode
   wire wr_rl_lo = bus_wr && (bus_addr == mmt_pkg::ADDR_RELOAD_LO);
   wire wr_rl_hi = bus_wr && (bus_addr == mmt_pkg::ADDR_RELOAD_HI);
   wire wr_ct_lo = bus_wr && (bus_addr == mmt_pkg::ADDR_COUNT_LO);
   wire wr_ct_hi = bus_wr && (bus_addr == mmt_pkg::ADDR_COUNT_HI);
   wire wr_ctrl  = bus_wr && (bus_addr == mmt_pkg::ADDR_CONTROL);

   // mode decode
   wire [2:0] mode       = ctrl_q[mmt_pkg::MODE_HI_BIT:mmt_pkg::MODE_LO_BIT];
   wire       cap_mode   = mode[1];                                // see (R8)
   wire       diff_mode  = mode[2] & mode[1];                      // see (R13)
   wire       evt_mode   = (mode == mmt_pkg::MODE_EVT_RISE) || (mode == mmt_pkg::MODE_EVT_FALL);
   wire       pwm_mode   = (mode == mmt_pkg::MODE_PWM_TGL) || (mode == mmt_pkg::MODE_PWM_PLAIN);
   wire       tgl_mode   = (mode == mmt_pkg::MODE_PWM_TGL);        // see (R11)
   wire       run        = ctrl_q[mmt_pkg::RUN_BIT];               // see (R3)
   wire       pin_lo_sel = ctrl_q[mmt_pkg::MODE_LO_BIT];
   wire       same_edge  = ctrl_q[mmt_pkg::CAPTYPE_BIT];           // see (R9)

   // timer clock: pin edge in event modes, every mclk otherwise
   wire evt_edge = pin_lo_sel ? edges.fall : edges.rise;           // see (R10)
   wire tick     = cap_mode ? 1'b1 :                               // see (R4)
                   (run && (evt_mode ? evt_edge : pwm_mode));       // see (R3)
   wire underflow = tick && (count_q == mmt_pkg::COUNT_ZERO);      // see (R5)

   // capture edges
   wire sel_edge   = pin_lo_sel ? edges.fall : edges.rise;         // see (R12)
   wire end_edge   = (pin_lo_sel ^ ~same_edge) ? edges.fall : edges.rise; // see (R13)
   wire std_cap    = cap_mode && !diff_mode && sel_edge;           // see (R12)
   wire diff_start = diff_mode && !armed_q && sel_edge;
   wire diff_cap   = diff_mode && armed_q && end_edge;
   wire capture    = std_cap || diff_cap;                          // see (R17)
   // cycle capture ends one period and starts the next on the same edge
   wire restart    = diff_start || (diff_cap && same_edge);

   // count register: a software byte write wins over counting
   always_comb begin
      count_d = count_q;
      if (restart) begin
         count_d = mmt_pkg::COUNT_FULL;
      end else if (underflow) begin
         count_d = cap_mode ? mmt_pkg::COUNT_FULL : reload_q;       // see (R5)
      end else if (tick) begin
         count_d = count_q - 16'h0001;                              // see (R4)
      end
      if (wr_ct_lo) begin
         count_d[7:0] = bus_wdata;                                  // see (R1)
      end
      if (wr_ct_hi) begin
         count_d[15:8] = bus_wdata;                                 // see (R1)
      end
   end

   always_comb begin
      reload_d = reload_q;
      if (wr_rl_lo) begin
         reload_d[7:0] = bus_wdata;                                 // see (R1)
      end
      if (wr_rl_hi) begin
         reload_d[15:8] = bus_wdata;                                // see (R1)
      end
      if (capture) begin
         reload_d = count_q;                                        // see (R17)
      end
   end

   // control: hardware setting a flag wins over a clearing write
   always_comb begin
      ctrl_d = wr_ctrl ? bus_wdata : ctrl_q;
      ctrl_d[0] = 1'b0;                                             // see (R9)
      if (underflow && !cap_mode) begin
         ctrl_d[mmt_pkg::PEND_BIT] = 1'b1;                          // see (R15)
      end
      if (capture) begin
         ctrl_d[mmt_pkg::PEND_BIT] = 1'b1;                          // see (R7)
      end
      if (underflow && cap_mode) begin
         ctrl_d[mmt_pkg::RUN_BIT] = 1'b1;                           // see (R8)
      end
   end

   always_comb begin
      armed_d = armed_q;
      if (!diff_mode) begin
         armed_d = 1'b0;
      end else if (diff_start) begin
         armed_d = 1'b1;
      end else if (diff_cap && !same_edge) begin
         armed_d = 1'b0;
      end
   end

   // toggle follows port data until toggling starts, so the wave starts at the port level
   assign toggle_d = !tgl_mode ? port_data_out :
                     (underflow ? ~toggle_q : toggle_q);            // see (R11)

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         count_q  <= mmt_pkg::COUNT_RESET;                          // see (R2)
         reload_q <= mmt_pkg::RELOAD_RESET;                         // see (R2)
         ctrl_q   <= mmt_pkg::CONTROL_RESET;                        // see (R2)
         toggle_q <= 1'b0;
         armed_q  <= 1'b0;
      end else begin
         count_q  <= count_d;
         reload_q <= reload_d;
         ctrl_q   <= ctrl_d;
         toggle_q <= toggle_d;
         armed_q  <= armed_d;
      end
   end

   // read data, one cycle after the read strobe
   wire [7:0] rd_mux =
      (bus_addr == mmt_pkg::ADDR_RELOAD_LO) ? reload_q[7:0]  :
      (bus_addr == mmt_pkg::ADDR_RELOAD_HI) ? reload_q[15:8] :
      (bus_addr == mmt_pkg::ADDR_COUNT_LO)  ? count_q[7:0]   :
      (bus_addr == mmt_pkg::ADDR_COUNT_HI)  ? count_q[15:8]  :
      (bus_addr == mmt_pkg::ADDR_CONTROL)   ? ctrl_q         :
      mmt_pkg::READ_UNMAPPED;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= mmt_pkg::READ_UNMAPPED;
      end else if (bus_rd) begin
         rdata_q <= rd_mux;
      end
   end
   assign bus_rdata = rdata_q;

   // interrupt source: pending flag, plus underflow flag in capture modes
   wire irq_src = ctrl_q[mmt_pkg::PEND_BIT] |
                  (cap_mode & ctrl_q[mmt_pkg::RUN_BIT]);            // see (R6)
   assign timer_interrupt = irq_src & ctrl_q[mmt_pkg::IEN_BIT] &
                            global_irq_enable;                      // see (R16)

   // port owns direction; the timer only replaces the level in toggle mode
   assign shared_port_pin_oe  = port_drive_en;                      // see (R14)
   assign shared_port_pin_out = tgl_mode ? toggle_q : port_data_out; // see (R14)
endmodule

// >>> mmt_pin_src.sv
`timescale 1ns/1ps
module mmt_pin_src (
   input  wire logic mclk,
   output logic      pin
);
   // idle level is the pin's pull-up
   initial pin = 1'b1;
   // one fall then one rise, each phase at least two clocks long
   task automatic pulse(input int w);
      @(posedge mclk) #1;
      pin = 1'b0;
      repeat (4) @(posedge mclk);
      #1 pin = 1'b1;
      repeat (w) @(posedge mclk);
   endtask
endmodule

// >>> mmt_timer_sva.sv
`timescale 1ns/1ps
module mmt_timer_sva (
   input wire logic       mclk,
   input wire logic       arst_n,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic       bus_wr,
   input wire logic       bus_rd,
   input wire logic [7:0] bus_rdata,
   input wire logic       global_irq_enable,
   input wire logic       timer_interrupt,
   input wire logic       port_data_out,
   input wire logic       port_drive_en,
   input wire logic       shared_port_pin_in,
   input wire logic       shared_port_pin_out,
   input wire logic       shared_port_pin_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   wire       ctl = bus_addr == mmt_pkg::ADDR_CONTROL;
   wire       unm = bus_addr < mmt_pkg::ADDR_RELOAD_LO || bus_addr > mmt_pkg::ADDR_CONTROL;
   wire [4:0] wsel = {bus_wdata[7:5], bus_wdata[2:1]};
   wire [4:0] rsel = {bus_rdata[7:5], bus_rdata[2:1]};
   property p_oe; shared_port_pin_oe == port_drive_en; endproperty
   a_oe: assert property (p_oe) else $error("pin enable differs from port direction");
   property p_gate; timer_interrupt |-> global_irq_enable; endproperty
   a_gate: assert property (p_gate) else $error("interrupt without global enable");
   property p_ien; bus_wr && ctl && !bus_wdata[2] |=> !timer_interrupt; endproperty
   a_ien: assert property (p_ien) else $error("interrupt while disabled");
   property p_hold; !bus_rd |=> $stable(bus_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved without a read");
   property p_unm; bus_rd && unm |=> bus_rdata == mmt_pkg::READ_UNMAPPED; endproperty
   a_unm: assert property (p_unm) else $error("unmapped read not zero");
   property p_rsv; bus_rd && ctl |=> !bus_rdata[0]; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved control bit reads one");
   property p_back; bus_wr && ctl ##1 !bus_wr ##1 (bus_rd && ctl && !bus_wr) |=> rsel == $past(wsel, 3); endproperty
   a_back: assert property (p_back) else $error("control fields not read back");
   property p_pout; bus_wr && ctl && bus_wdata[7:5] != mmt_pkg::MODE_PWM_TGL |=> shared_port_pin_out == port_data_out;
   endproperty
   a_pout: assert property (p_pout) else $error("pin out not port data outside toggle mode");
endmodule
bind mmt_timer mmt_timer_sva i_sva (.mclk(mclk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
   .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .global_irq_enable(global_irq_enable),
   .timer_interrupt(timer_interrupt), .port_data_out(port_data_out), .port_drive_en(port_drive_en),
   .shared_port_pin_in(shared_port_pin_in), .shared_port_pin_out(shared_port_pin_out),
   .shared_port_pin_oe(shared_port_pin_oe));

// >>> mmt_timer_test.sv
`timescale 1ns/1ps
module mmt_timer_test;
   logic       mclk = 0, arst_n = 0, wr = 0, rd = 0, gie = 0, pdo = 0, pden = 0;
   logic [7:0] addr = 0, wdata = 0, rdata, d1;
   logic [7:0] cap [2];
   logic [7:0] evm [2] = '{8'h30, 8'h10};
   logic [7:0] dfm [2] = '{8'hC0, 8'hC2};
   int         wid [2] = '{6, 16};
   logic       irq, pout, poe, src;
   wire        pin_in = poe ? pout : src;
   int         errors = 0, n_compared = 0, cyc = 0, nt;
   always #50 mclk = ~mclk;
   mmt_pin_src i_src (.mclk(mclk), .pin(src));
   mmt_timer i_dut (.mclk(mclk), .arst_n(arst_n), .bus_addr(addr), .bus_wdata(wdata), .bus_wr(wr), .bus_rd(rd),
      .bus_rdata(rdata), .global_irq_enable(gie), .timer_interrupt(irq), .port_data_out(pdo),
      .port_drive_en(pden), .shared_port_pin_in(pin_in), .shared_port_pin_out(pout), .shared_port_pin_oe(poe));
   task chk(input string n, input logic [7:0] s, e);
      n_compared++;
      if (s !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task wb(input logic [7:0] a, v);
      @(posedge mclk) #1;
      addr = a; wdata = v; wr = 1;
      @(posedge mclk) #1;
      wr = 0;
   endtask
   task rb(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk) #1;
      addr = a; rd = 1;
      @(posedge mclk) #1;
      rd = 0; d = rdata;
   endtask
   task rc(input logic [7:0] a, m, e, input string n);
      rb(a, d1);
      chk(n, d1 & m, e);
   endtask
   task cy(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task test_done;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         errors++;
         test_done;
      end
   end
   initial begin
      cy(4);
      arst_n = 1;
      rc(8'hAC, 8'hFF, 8'hFF, "count_low_byte");
      rc(8'hAD, 8'hFF, 8'hFF, "count_high_byte");
      rc(8'hAA, 8'hFF, 8'h00, "reload_low_byte");
      rc(8'hAB, 8'hFF, 8'h00, "reload_high_byte");
      rc(8'hAE, 8'hFF, 8'h00, "timer_control");
      rc(8'hAF, 8'hFF, 8'h00, "unmapped");
      gie = 1;
      // a short start count so the first underflow comes within a few clocks
      wb(8'hAD, 8'h00);
      wb(8'hAC, 8'h01);
      wb(8'hAE, 8'h94);
      cy(4);
      chk("irq_pwm", irq, 8'h01);
      gie = 0;
      #1;
      chk("irq_gated", irq, 8'h00);
      // a stop write can race a final underflow, so the clear is written twice
      wb(8'hAE, 8'h84);
      wb(8'hAE, 8'h84);
      rc(8'hAE, 8'hFF, 8'h84, "ctl_stopped");
      wb(8'hAC, 8'h10);
      cy(5);
      rc(8'hAC, 8'hFF, 8'h10, "count_held");
      pden = 1;
      wb(8'hAA, 8'h04);
      wb(8'hAC, 8'h04);
      wb(8'hAE, 8'hB0);
      cy(3);
      nt = 0;
      repeat (20) begin
         d1[0] = pout;
         cy(1);
         nt += (pout !== d1[0]);
      end
      chk("toggles", nt[7:0], 8'h04);
      pden = 0;
      wb(8'hAE, 8'h80);
      foreach (evm[i]) begin
         wb(8'hAC, 8'h05);
         wb(8'hAE, evm[i]);
         repeat (3) i_src.pulse(4);
         cy(5);
         rc(8'hAC, 8'hFF, 8'h02, "event_count");
      end
      wb(8'hAC, 8'h03);
      wb(8'hAE, 8'h40);
      cy(8);
      i_src.pulse(4);
      cy(5);
      rc(8'hAE, 8'h18, 8'h18, "capture_flags");
      rc(8'hAB, 8'hFF, 8'hFF, "capture_high");
      foreach (dfm[i]) begin
         wb(8'hAE, dfm[i]);
         foreach (wid[j]) begin
            i_src.pulse(wid[j]);
            i_src.pulse(4);
            cy(6);
            rb(8'hAA, cap[j]);
         end
         chk("difference", cap[0] - cap[1], 8'h0A);
      end
      test_done;
   end
endmodule
